// file: hw/acs_pkg.sv
// Package of register map, field layout, timing and type definitions for the sequencer.
package acs_pkg;

  // ***************************************************************
  // Register offsets (byte addresses on APB).
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // ***************************************************************
  // Field positions.
  // ***************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CTRL_PROC_LSB = 12;
  localparam int TRIG_DLY_LSB = 0;
  localparam int TRIG_GAP_LSB = 4;
  localparam int TRIG_REPEAT_BIT = 8;
  localparam int TRIG_HOLDOFF_BIT = 9;
  localparam int TRIG_EDGE_BIT = 10;
  localparam int TRIG_EXT_BIT = 11;
  localparam int LIMIT_LO_LSB = 16;

  // ***************************************************************
  // Reset values.
  // ***************************************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TRIG_RESET = 32'h0000_0000;
  localparam logic [10:0] UPPER_LIMIT_RESET = 11'h7FF;
  localparam logic [10:0] LOWER_LIMIT_RESET = 11'h000;

  // ***************************************************************
  // Timing: trigger delay step 50 us, clock period 5 ns.
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DLY_STEP_US = 50;
  localparam int DLY_STEP_CYC = (DLY_STEP_US * 1000000) / CLK_PERIOD_PS;
  localparam int GAP_UNIT_US = 20;
  localparam int GAP_UNIT_CYC = (GAP_UNIT_US * 1000000) / CLK_PERIOD_PS;

  // Result selections.
  typedef enum logic [1:0]
  {
    SEL_LAST = 2'b00,
    SEL_AVG = 2'b01,
    SEL_MAX = 2'b10,
    SEL_MIN = 2'b11
  } acs_sel_e;

  // Sequencer states.
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ARM = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONV = 3'b011,
    ST_GAP = 3'b100,
    ST_FINISH = 3'b101
  } acs_state_e;

  // Converter answer carrier: valid flag and 10-bit sample.
  typedef struct packed
  {
    logic valid;
    logic [9:0] data;
  } acs_sample_s;

endpackage

// file: hw/acs_sequencer.sv
// Conversion cycle sequencer with APB register slave for a 10-bit SAR converter.
module acs_sequencer #(
  parameter int CNT_MAX = 256,
  parameter int DLY_STEP = acs_pkg::DLY_STEP_CYC,
  parameter int GAP_UNIT = acs_pkg::GAP_UNIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_pin,
  input wire acs_pkg::acs_sample_s conv_result,
  output logic conv_start,
  output logic irq_n
);

  // ***************************************************************
  // Registers and state.
  // ***************************************************************
  logic [31:0] ctrl_q;
  logic [31:0] trig_q;
  logic [10:0] upper_limit_q;
  logic [10:0] lower_limit_q;
  logic mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_n_q;
  logic conv_start_q;
  acs_pkg::acs_state_e state_q;
  logic [31:0] shadow_ctrl_q;
  logic [31:0] shadow_trig_q;
  logic busy_q;
  logic done_flag_q;
  logic en_prev_q;
  logic [2:0] sync_q;
  logic [31:0] timer_q;
  logic [8:0] taken_q;
  logic edge_seen_q;
  logic [9:0] last_q;
  logic [9:0] max_q;
  logic [9:0] min_q;
  logic [17:0] sum_q;
  logic [10:0] res_last_q;
  logic [10:0] res_avg_q;
  logic [10:0] res_max_q;
  logic [10:0] res_min_q;

  // Sample count decode: code n gives 1, 4, 8 ... 256.
  function automatic logic [8:0] count_of(input logic [2:0] code);
    return (code == 3'b000) ? 9'h001 : 9'(9'h002 << code);
  endfunction
  // Wait-time decode in units of 20 us, steps follow the converter table.
  function automatic logic [10:0] gap_units(input logic [3:0] code);
    logic [10:0] u;
    u = 11'h000;
    case (code)
      4'h0: u = 11'd0;
      4'h1: u = 11'd1;
      4'h2: u = 11'd2;
      4'h3: u = 11'd3;
      4'h4: u = 11'd4;
      4'h5: u = 11'd8;
      4'h6: u = 11'd12;
      4'h7: u = 11'd16;
      4'h8: u = 11'd32;
      4'h9: u = 11'd64;
      4'hA: u = 11'd96;
      4'hB: u = 11'd128;
      4'hC: u = 11'd256;
      4'hD: u = 11'd512;
      4'hE: u = 11'd768;
      default: u = 11'd1024;
    endcase
    return u;
  endfunction

  // ***************************************************************
  // Decode of configuration and trigger conditions.
  // ***************************************************************
  wire logic apb_setup = psel && !penable;
  wire logic apb_wr = psel && penable && pready_q && pwrite; // Lands at the completing edge.
  wire logic wr_ctrl = apb_wr && (paddr == acs_pkg::ADDR_CTRL);
  wire logic wr_trig = apb_wr && (paddr == acs_pkg::ADDR_TRIG);
  wire logic wr_limit = apb_wr && (paddr == acs_pkg::ADDR_LIMIT);
  wire logic wr_mask = apb_wr && (paddr == acs_pkg::ADDR_MASK);
  wire logic addr_ok = (paddr == acs_pkg::ADDR_CTRL) || (paddr == acs_pkg::ADDR_TRIG) ||
                       (paddr == acs_pkg::ADDR_LIMIT) || (paddr == acs_pkg::ADDR_STATUS) ||
                       (paddr == acs_pkg::ADDR_RESULT) || (paddr == acs_pkg::ADDR_MASK);
  wire logic en_bit = ctrl_q[acs_pkg::CTRL_EN_BIT];
  wire logic en_rise = en_bit && !en_prev_q;
  wire logic ext_mode = shadow_trig_q[acs_pkg::TRIG_EXT_BIT];
  wire logic rising_sel = shadow_trig_q[acs_pkg::TRIG_EDGE_BIT];
  wire logic holdoff = shadow_trig_q[acs_pkg::TRIG_HOLDOFF_BIT];
  wire logic repeat_mode = trig_q[acs_pkg::TRIG_REPEAT_BIT];
  wire logic pin_s = sync_q[1];
  wire logic pin_prev = sync_q[2];
  // active level is high for rising-edge mode, low for falling.
  wire logic pin_active = rising_sel ? pin_s : !pin_s;
  wire logic edge_hit = rising_sel ? (pin_s && !pin_prev) : (!pin_s && pin_prev);
  wire logic [8:0] n_samples = count_of(shadow_ctrl_q[acs_pkg::CTRL_CNT_LSB +: 3]);
  wire logic [1:0] proc_mode = shadow_ctrl_q[acs_pkg::CTRL_PROC_LSB +: 2];
  wire logic [31:0] dly_cycles = 32'(shadow_trig_q[acs_pkg::TRIG_DLY_LSB +: 4]) * 32'(DLY_STEP);
  wire logic [31:0] gap_cycles =
    32'(gap_units(shadow_trig_q[acs_pkg::TRIG_GAP_LSB +: 4])) * 32'(GAP_UNIT);
  wire logic [10:0] sample11 = {1'b0, conv_result.data};
  wire logic out_of_range = (sample11 > upper_limit_q) || (sample11 < lower_limit_q);
  wire logic last_sample = (taken_q + 9'h001) == n_samples;
  wire logic [17:0] sum_next = sum_q + 18'(conv_result.data);
  wire logic [9:0] max_next = (taken_q == 9'h000 || conv_result.data > max_q) ?
                              conv_result.data : max_q;
  wire logic [9:0] min_next = (taken_q == 9'h000 || conv_result.data < min_q) ?
                              conv_result.data : min_q;
  wire logic [17:0] avg_full = sum_next / 18'(n_samples);
  wire logic [1:0] sel_now = ctrl_q[acs_pkg::CTRL_SEL_LSB +: 2];
  wire logic [10:0] result_sel = (sel_now == acs_pkg::SEL_LAST) ? res_last_q :
                                 (sel_now == acs_pkg::SEL_AVG) ? res_avg_q :
                                 (sel_now == acs_pkg::SEL_MAX) ? res_max_q : res_min_q;
  wire logic [31:0] rd_mux =
    (paddr == acs_pkg::ADDR_CTRL) ? ctrl_q :
    (paddr == acs_pkg::ADDR_TRIG) ? trig_q :
    (paddr == acs_pkg::ADDR_LIMIT) ?
      {5'h00, lower_limit_q, 5'h00, upper_limit_q} :
    (paddr == acs_pkg::ADDR_STATUS) ? {30'h0000_0000, done_flag_q, busy_q} :
    (paddr == acs_pkg::ADDR_RESULT) ? {21'h00_0000, result_sel} :
    (paddr == acs_pkg::ADDR_MASK) ? {31'h0000_0000, mask_q} : 32'h0000_0000;

  // ***************************************************************
  // APB slave: answers in the access phase, one wait-free cycle.
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !addr_ok;
      prdata_q <= apb_setup && !pwrite ? rd_mux : 32'h0000_0000;
    end
  end
  // Software-written registers; the selector keeps its value while busy.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= acs_pkg::CTRL_RESET;
      trig_q <= acs_pkg::TRIG_RESET;
      upper_limit_q <= acs_pkg::UPPER_LIMIT_RESET;
      lower_limit_q <= acs_pkg::LOWER_LIMIT_RESET;
      mask_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= {pwdata[31:10], busy_q ? sel_now : pwdata[9:8], pwdata[7:0]};
      end
      if (wr_trig)
      begin
        trig_q <= pwdata;
      end
      if (wr_limit)
      begin
        upper_limit_q <= pwdata[10:0];
        lower_limit_q <= pwdata[acs_pkg::LIMIT_LO_LSB +: 11];
      end
      if (wr_mask)
      begin
        mask_q <= pwdata[0];
      end
    end
  end
  // Two-flop synchroniser plus one history stage for edge detection.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_q <= 3'b000;
    end
    else
    begin
      sync_q <= {sync_q[1:0], external_trigger_pin};
    end
  end

  // ***************************************************************
  // Cycle sequencer.
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= acs_pkg::ST_IDLE;
      shadow_ctrl_q <= acs_pkg::CTRL_RESET;
      shadow_trig_q <= acs_pkg::TRIG_RESET;
      busy_q <= 1'b0;
      done_flag_q <= 1'b0;
      en_prev_q <= 1'b0;
      timer_q <= 32'h0000_0000;
      taken_q <= 9'h000;
      edge_seen_q <= 1'b0;
      conv_start_q <= 1'b0;
      irq_n_q <= 1'b1;
      last_q <= 10'h000;
      max_q <= 10'h000;
      min_q <= 10'h000;
      sum_q <= 18'h0_0000;
      res_last_q <= 11'h000;
      res_avg_q <= 11'h000;
      res_max_q <= 11'h000;
      res_min_q <= 11'h000;
    end
    else
    begin
      en_prev_q <= en_bit;
      conv_start_q <= 1'b0;
      // A write to the status word acknowledges the interrupt, except in the cycle where ST_FINISH raises it again.
      if (apb_wr && paddr == acs_pkg::ADDR_STATUS)
      begin
        irq_n_q <= 1'b1;
      end
      case (state_q)
        acs_pkg::ST_IDLE:
        begin
          if (en_rise)
          begin
            // Configuration is captured here and held through the cycle, except the repeat bit, which is read live from trig_q.
            shadow_ctrl_q <= ctrl_q;
            shadow_trig_q <= trig_q;
            busy_q <= 1'b1;
            done_flag_q <= 1'b0;
            taken_q <= 9'h000;
            sum_q <= 18'h0_0000;
            edge_seen_q <= 1'b0;
            state_q <= acs_pkg::ST_ARM;
          end
        end
        acs_pkg::ST_ARM:
        begin
          // Internal trigger fires at once; external waits forever for an edge.
          if (!ext_mode)
          begin
            conv_start_q <= 1'b1;
            state_q <= acs_pkg::ST_CONV;
          end
          else if (edge_hit)
          begin
            timer_q <= dly_cycles;
            state_q <= acs_pkg::ST_DELAY;
          end
        end
        acs_pkg::ST_DELAY:
        begin
          if (timer_q != 32'h0000_0000)
          begin
            timer_q <= timer_q - 32'h0000_0001;
          end
          else if (pin_active)
          begin
            conv_start_q <= 1'b1;
            edge_seen_q <= 1'b0;
            state_q <= acs_pkg::ST_CONV;
          end
          else
          begin
            state_q <= acs_pkg::ST_ARM;
          end
        end
        acs_pkg::ST_CONV:
        begin
          if (conv_result.valid)
          begin
            // ALU: all statistics always tracked, processing mode only shapes last.
            last_q <= conv_result.data;
            max_q <= max_next;
            min_q <= min_next;
            sum_q <= sum_next;
            taken_q <= taken_q + 9'h001;
            if (last_sample || (n_samples != 9'h001 && out_of_range))
            begin
              res_max_q <= {1'b0, max_next};
              res_min_q <= {1'b0, min_next};
              res_avg_q <= avg_full[10:0];
              res_last_q <= (proc_mode == 2'b01) ? avg_full[10:0] :
                            (proc_mode == 2'b10) ? {1'b0, max_next} :
                            (proc_mode == 2'b11) ? {1'b0, min_next} : sample11;
              state_q <= acs_pkg::ST_FINISH;
              // in continuous mode only a limit breach raises done.
              done_flag_q <= !repeat_mode || out_of_range;
            end
            else
            begin
              timer_q <= gap_cycles;
              state_q <= acs_pkg::ST_GAP;
            end
          end
        end
        acs_pkg::ST_GAP:
        begin
          if (ext_mode && holdoff && edge_hit)
          begin
            edge_seen_q <= 1'b1;
          end
          if (timer_q != 32'h0000_0000)
          begin
            timer_q <= timer_q - 32'h0000_0001;
          end
          else if (!ext_mode || !holdoff)
          begin
            conv_start_q <= 1'b1;
            state_q <= acs_pkg::ST_CONV;
          end
          else if ((edge_seen_q || edge_hit) && pin_active)
          begin
            conv_start_q <= 1'b1;
            edge_seen_q <= 1'b0;
            state_q <= acs_pkg::ST_CONV;
          end
        end
        acs_pkg::ST_FINISH:
        begin
          // A repeat bit cleared late still ends this cycle as a reported one.
          if (done_flag_q || !repeat_mode)
          begin
            busy_q <= 1'b0;
            done_flag_q <= 1'b1;
            irq_n_q <= !mask_q;
            state_q <= acs_pkg::ST_IDLE;
          end
          else if (!en_bit)
          begin
            busy_q <= 1'b0;
            state_q <= acs_pkg::ST_IDLE;
          end
          else
          begin
            // Continuous mode: restart with the live settings, no done flag.
            shadow_ctrl_q <= ctrl_q;
            shadow_trig_q <= trig_q;
            taken_q <= 9'h000;
            sum_q <= 18'h0_0000;
            edge_seen_q <= 1'b0;
            state_q <= acs_pkg::ST_ARM;
          end
        end
        default:
        begin
          state_q <= acs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Outputs straight from flip-flops.
  // ***************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_start = conv_start_q;
  assign irq_n = irq_n_q;

endmodule

// file: tb/acs_sequencer_monitor.sv
// Port-level checker for the conversion cycle sequencer.
module acs_sequencer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_trigger_pin,
  input wire acs_pkg::acs_sample_s conv_result,
  input wire logic conv_start,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***************************************************************
  // Helper logic.
  // ***************************************************************
  logic stat_wr;
  logic pend_q;
  logic [3:0] since_q;
  assign stat_wr = psel && penable && pready && pwrite && (paddr == acs_pkg::ADDR_STATUS);
  // Tracks an open converter request and the age of the last answer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      since_q <= 4'hF;
    end
    else
    begin
      pend_q <= conv_start || (pend_q && !conv_result.valid);
      since_q <= conv_result.valid ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
    end
  end
  // ***************************************************************
  // Assertions.
  // ***************************************************************
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_SINGLE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_IDLE_DATA_ZERO: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  AST_UNMAPPED_ERR: assert property (psel && !penable && paddr > acs_pkg::ADDR_MASK |=> pslverr)
    else $error("unmapped access not refused");
  AST_ONE_REQUEST: assert property (conv_start |-> !pend_q)
    else $error("start while a conversion is open");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  AST_IRQ_AFTER_SAMPLE: assert property ($fell(irq_n) |-> since_q <= 4'h6)
    else $error("interrupt without a recent sample");
  AST_IRQ_HOLDS: assert property (!irq_n && !stat_wr |=> !irq_n)
    else $error("interrupt released on its own");
  AST_IRQ_RELEASE: assert property (stat_wr |=> irq_n)
    else $error("interrupt not released by status write");
  // A few cover points for the main scenarios.
  COV_IRQ: cover property ($fell(irq_n));
  COV_ERR: cover property (pslverr);
  COV_CONV: cover property (conv_start ##[1:20] conv_result.valid);
endmodule

bind acs_sequencer acs_sequencer_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_trigger_pin(external_trigger_pin),
  .conv_result(conv_result), .conv_start(conv_start), .irq_n(irq_n));

// file: tb/acs_conv_model.sv
// Behavioural converter that answers each start request after a short or long latency.
module acs_conv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic slow,
  input wire logic [9:0] sample_in,
  output acs_pkg::acs_sample_s conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  logic [9:0] last;
  // Outside the answer cycle the data lines show the inverse of the last sample.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_cnt <= 0;
      conv_result <= '0;
      last = 10'h000;
    end
    else
    begin
      conv_result.valid <= 1'b0;
      conv_result.data <= ~last;
      if (conv_start)
        wait_cnt <= slow ? 6 : 1;
      else if (wait_cnt > 0)
        wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1 && !conv_start)
      begin
        conv_result.valid <= 1'b1;
        conv_result.data <= sample_in;
        last = sample_in;
      end
    end
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the conversion cycle sequencer.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig_pin = 1'b0;
  logic slow = 1'b0;
  logic [31:0] seed = 32'h6123_77b8;
  acs_pkg::acs_sample_s conv_result;
  logic conv_start;
  logic irq_n;
  int failures = 0;
  int samples_checked = 0;
  int n_starts = 0;
  int since_v = 0;
  int gap_seen = 0;
  int n;
  int codes[3] = '{0, 1, 7};
  logic [9:0] q[$];
  logic [31:0] rd;
  logic [31:0] ctrl;
  logic err;
  logic gap_bit;

  always #2.5 pclk = ~pclk;

  acs_sequencer #(.CNT_MAX(256), .DLY_STEP(4), .GAP_UNIT(2)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_pin(trig_pin), .conv_result(conv_result), .conv_start(conv_start),
    .irq_n(irq_n));
  acs_conv_model conv_u (.clk(pclk), .rst_n(presetn), .conv_start(conv_start), .slow(slow),
    .sample_in(seed[9:0] | 10'h001), .conv_result(conv_result));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected result for slot k: 0 last, 1 average, 2 maximum, 3 minimum.
  function automatic logic [31:0] pick(input int k);
    logic [31:0] mn = 32'h0000_03FF;
    logic [31:0] mx = 32'h0000_0000;
    logic [31:0] sum = 32'h0000_0000;
    foreach (q[i])
    begin
      sum += q[i];
      if (q[i] < mn) mn = q[i];
      if (q[i] > mx) mx = q[i];
    end
    case (k)
      0: return {22'h0, q[$]};
      1: return sum / q.size();
      2: return mx;
      default: return mn;
    endcase
  endfunction

  // Random data source, sample record, start counter and answer-to-start gap.
  always @(posedge pclk)
  begin
    seed <= lfsr(seed);
    if (conv_result.valid === 1'b1) q.push_back(conv_result.data);
    if (conv_start === 1'b1) n_starts <= n_starts + 1;
    since_v <= (conv_result.valid === 1'b1) ? 0 : since_v + 1;
    if (conv_start === 1'b1) gap_seen <= since_v + 1;
  end

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(k < 50), 32'h0000_0001);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_n !== 1'b0 && k < 20000)
    begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k < 20000), 32'h0000_0001);
  endtask

  // Drops enable, clears the interrupt, then raises enable from 0 to 1.
  task automatic start(input logic [31:0] c);
    apb(1'b1, acs_pkg::ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, acs_pkg::ADDR_STATUS, 32'h0000_0000);
    q.delete();
    n_starts = 0;
    apb(1'b1, acs_pkg::ADDR_CTRL, c | 32'h0000_0001);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #400000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, acs_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rd, acs_pkg::CTRL_RESET);
    apb(1'b0, acs_pkg::ADDR_LIMIT, 32'h0000_0000);
    chk(rd, {5'h0, acs_pkg::LOWER_LIMIT_RESET, 5'h0, acs_pkg::UPPER_LIMIT_RESET});
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, acs_pkg::ADDR_MASK, 32'h0000_0001);
    // Every processing mode at the smallest, the second smallest and the largest count.
    foreach (codes[c])
      for (int p = 0; p < 4; p++)
      begin
        slow <= seed[3];
        gap_bit = seed[4];
        apb(1'b1, acs_pkg::ADDR_TRIG, 32'(gap_bit) << acs_pkg::TRIG_GAP_LSB);
        ctrl = (32'(codes[c]) << acs_pkg::CTRL_CNT_LSB) | (32'(p) << acs_pkg::CTRL_PROC_LSB);
        start(ctrl);
        if (codes[c] != 0)
        begin
          apb(1'b1, acs_pkg::ADDR_CTRL, ctrl | 32'h0000_0301);
          apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0000_0000);
          chk(rd & 32'h0000_0001, 32'h0000_0001);
        end
        wait_irq();
        apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        apb(1'b0, acs_pkg::ADDR_CTRL, 32'h0000_0000);
        chk(rd, ctrl | 32'h0000_0001);
        chk(32'(q.size()), (codes[c] == 0) ? 1 : (2 << codes[c]));
        // Code 1 is one unit of two cycles; two more edges pass from answer to next start.
        if (codes[c] != 0) chk(32'(gap_seen), 2 + 2 * 32'(gap_bit));
        for (int s = 0; s < 4; s++)
        begin
          apb(1'b1, acs_pkg::ADDR_CTRL, ctrl | 32'h0000_0001 | (32'(s) << 8));
          apb(1'b0, acs_pkg::ADDR_RESULT, 32'h0000_0000);
          chk(rd, pick((s == 0) ? p : s));
        end
      end
    // Both limits at zero: the first nonzero sample ends an eight-sample cycle.
    apb(1'b1, acs_pkg::ADDR_LIMIT, 32'h0000_0000);
    start(32'h0000_0020);
    wait_irq();
    chk(32'(q.size()), 32'h0000_0001);
    apb(1'b1, acs_pkg::ADDR_LIMIT, 32'h0000_07FF);
    // External trigger on each edge: idle arm, a too-short pulse, then a real edge.
    for (int e = 0; e < 2; e++)
    begin
      trig_pin <= !e;
      apb(1'b1, acs_pkg::ADDR_TRIG, 32'h0000_0800 | (32'(e) << 10) | 32'(3 - e));
      start(32'h0000_0000);
      apb(1'b0, acs_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      repeat (40) @(posedge pclk);
      chk({n_starts[30:0], irq_n}, 32'h0000_0001);
      trig_pin <= e;
      repeat (3) @(posedge pclk);
      trig_pin <= !e;
      repeat (30) @(posedge pclk);
      chk(32'(n_starts), 32'h0000_0000);
      trig_pin <= e;
      n = 0;
      while (conv_start !== 1'b1 && n < 100)
      begin
        @(posedge pclk);
        n++;
      end
      chk(32'(n >= 4 * (3 - e) && n <= 4 * (3 - e) + 10), 32'h0000_0001);
      wait_irq();
      chk(32'(q.size()), 32'h0000_0001);
    end
    // Repeat mode restarts silently until the repeat bit is cleared.
    apb(1'b1, acs_pkg::ADDR_TRIG, 32'h0000_0100);
    start(32'h0000_0000);
    repeat (60) @(posedge pclk);
    chk({31'h0, irq_n}, 32'h0000_0001);
    chk(32'(n_starts > 2), 32'h0000_0001);
    apb(1'b1, acs_pkg::ADDR_TRIG, 32'h0000_0000);
    wait_irq();
    give_verdict();
  end
endmodule
